// ==== design/serial_peripheral_port.sv ====
// Master and slave byte serial port with receive stream FIFO
`timescale 1ns/10ps
module serial_peripheral_port
  import spi_port_pkg::*;
#(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire logic             i_enable,
  input  wire logic             i_power_reduce,
  input  wire logic             i_idle_sleep,
  input  wire logic             i_ctrl_wr,
  input  wire port_control_type i_ctrl,
  input  wire pin_dir_type      i_pin_dir,
  input  wire logic             i_data_wr,
  input  wire logic [7:0]       i_data_wdata,
  input  wire logic             i_rx_read,
  input  wire logic             i_flag_clear,
  input  wire logic             i_stream_ready,
  input  wire logic             i_sck_i,
  input  wire logic             i_mosi_i,
  input  wire logic             i_miso_i,
  input  wire logic             i_ss_n_i,
  output logic                  o_sck_o,
  output logic                  o_sck_oe,
  output logic                  o_mosi_o,
  output logic                  o_mosi_oe,
  output logic                  o_miso_o,
  output logic                  o_miso_oe,
  output port_control_type      o_ctrl,
  output logic [7:0]            o_rx_data,
  output logic                  o_transfer_done_flag,
  output logic                  o_write_collision_flag,
  output logic                  o_rx_overrun,
  output logic                  o_data_ready,
  output logic                  o_irq,
  output logic                  o_wake_req,
  output logic                  o_stream_valid,
  output logic [7:0]            o_stream_data
);

  if (FIFO_DEPTH < 2) begin : g_chk
    $error("serial_peripheral_port needs a FIFO of two words or more");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0]       meta_reg;
  logic [3:0]       sync_reg;
  logic             sck_s;
  logic             ss_n_s;
  logic             mosi_s;
  logic             miso_s;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= SYNC_RESET;
      sync_reg <= SYNC_RESET;
    end else begin
      meta_reg <= {i_sck_i, i_ss_n_i, i_mosi_i, i_miso_i};
      sync_reg <= meta_reg;
    end
  end

  assign {sck_s, ss_n_s, mosi_s, miso_s} = sync_reg;

  // ----------------------------------------
  // Control and state
  // ----------------------------------------
  port_control_type ctrl_reg;
  port_state_type   state_reg;
  logic             enabled;
  logic [5:0]       half_cnt_reg;
  logic [3:0]       edge_cnt_reg;
  logic [3:0]       bit_cnt_reg;
  logic             sck_level_reg;
  logic             sck_prev_reg;
  logic [7:0]       tx_reg;
  logic [7:0]       rx_reg;
  logic [7:0]       rx_next;
  logic             out_bit_reg;
  logic [5:0]       half_sel;
  logic             fault;
  logic             busy;
  logic             write_ok;
  logic             start;
  logic             edge_ev;
  logic             leading;
  logic             sample;
  logic             setup;
  logic             done;
  logic             m_edge;
  logic             fifo_in_ready;
  logic             unread_reg;
  logic             collide;
  logic [10:0]      byte_cyc_reg;

  assign enabled = i_enable & ~i_power_reduce;

  always_comb begin
    case ({ctrl_reg.double_rate_bit, ctrl_reg.rate_select_high,
           ctrl_reg.rate_select_low})
      3'h0:    half_sel = HALF_DIV4;
      3'h1:    half_sel = HALF_DIV16;
      3'h2:    half_sel = HALF_DIV64;
      3'h3:    half_sel = HALF_DIV128 + 6'h01;
      3'h4:    half_sel = HALF_DIV2;
      3'h5:    half_sel = HALF_DIV8;
      3'h6:    half_sel = HALF_DIV32;
      default: half_sel = HALF_DIV64;
    endcase
  end

  assign fault = enabled & ctrl_reg.master_select_bit
               & i_pin_dir.ss_is_input & ~ss_n_s;

  assign busy = (state_reg == ST_MASTER)
              | ((state_reg == ST_SLAVE) & (bit_cnt_reg != 4'h0));

  assign collide  = enabled & i_data_wr & busy;
  assign write_ok = enabled & i_data_wr & ~busy & ~fault
                  & (fifo_in_ready | ~ctrl_reg.master_select_bit);
  assign start    = write_ok & ctrl_reg.master_select_bit;

  assign m_edge  = (state_reg == ST_MASTER) & (half_cnt_reg == 6'h00);
  assign edge_ev = m_edge
                 | ((state_reg == ST_SLAVE) & (sck_s != sck_prev_reg));
  assign leading = (state_reg == ST_MASTER) ? ~edge_cnt_reg[0]
                 : (sck_s != ctrl_reg.idle_level_select);
  assign sample  = edge_ev & (leading ^ ctrl_reg.sample_edge_select);
  assign setup   = edge_ev & ~(leading ^ ctrl_reg.sample_edge_select);

  always_comb begin
    rx_next = rx_reg;
    if (sample) begin
      if (ctrl_reg.bit_order_select) begin
        rx_next = {(ctrl_reg.master_select_bit ? miso_s : mosi_s), rx_reg[7:1]};
      end else begin
        rx_next = {rx_reg[6:0], (ctrl_reg.master_select_bit ? miso_s : mosi_s)};
      end
    end
  end

  assign done = (m_edge & (edge_cnt_reg == 4'(EDGES_BYTE - 1)))
              | ((state_reg == ST_SLAVE) & sample & (bit_cnt_reg == 4'(BYTE_W - 1)));

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (fault) begin
      ctrl_reg                   <= i_ctrl_wr ? i_ctrl : ctrl_reg;
      ctrl_reg.master_select_bit <= 1'b0;
    end else if (i_ctrl_wr) begin
      ctrl_reg <= i_ctrl;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_MASTER;
          end else if (enabled & ~ctrl_reg.master_select_bit & ~ss_n_s) begin
            state_reg <= ST_SLAVE;
          end
        end
        ST_MASTER: begin
          if (~enabled | fault | done) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_SLAVE: begin
          if (~enabled | ss_n_s | ctrl_reg.master_select_bit) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Clock generator and bit counters
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      half_cnt_reg <= 6'h00;
      edge_cnt_reg <= 4'h0;
    end else if (start) begin
      half_cnt_reg <= half_sel - 6'h01;
      edge_cnt_reg <= 4'h0;
    end else if (m_edge) begin
      half_cnt_reg <= half_sel - 6'h01;
      edge_cnt_reg <= edge_cnt_reg + 4'h1;
    end else if (state_reg == ST_MASTER) begin
      half_cnt_reg <= half_cnt_reg - 6'h01;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sck_level_reg <= 1'b0;
      sck_prev_reg  <= 1'b0;
    end else begin
      sck_prev_reg <= sck_s;
      if (m_edge & ~fault) begin
        sck_level_reg <= ~sck_level_reg;
      end else if (state_reg != ST_MASTER) begin
        sck_level_reg <= ctrl_reg.idle_level_select;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt_reg <= 4'h0;
    end else if (start | done | (state_reg == ST_IDLE)) begin
      bit_cnt_reg <= 4'h0;
    end else if (sample) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // ----------------------------------------
  // Shift registers
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_reg      <= DATA_RESET;
      out_bit_reg <= 1'b0;
    end else if (write_ok) begin
      tx_reg      <= i_data_wdata;
      out_bit_reg <= ctrl_reg.bit_order_select ? i_data_wdata[0] : i_data_wdata[7];
    end else if (setup & (bit_cnt_reg != 4'h0)) begin
      if (ctrl_reg.bit_order_select) begin
        tx_reg      <= {1'b0, tx_reg[7:1]};
        out_bit_reg <= tx_reg[1];
      end else begin
        tx_reg      <= {tx_reg[6:0], 1'b0};
        out_bit_reg <= tx_reg[6];
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_reg <= DATA_RESET;
    end else begin
      rx_reg <= rx_next;
    end
  end

  // ----------------------------------------
  // Receive buffer and status
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_data  <= DATA_RESET;
      unread_reg <= 1'b0;
    end else if (done) begin
      o_rx_data  <= rx_next;
      unread_reg <= 1'b1;
    end else if (i_rx_read) begin
      unread_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_transfer_done_flag   <= 1'b0;
      o_write_collision_flag <= 1'b0;
      o_rx_overrun           <= 1'b0;
    end else begin
      if (done | fault) begin
        o_transfer_done_flag <= 1'b1;
      end else if (i_flag_clear) begin
        o_transfer_done_flag <= 1'b0;
      end
      if (collide) begin
        o_write_collision_flag <= 1'b1;
      end else if (i_flag_clear) begin
        o_write_collision_flag <= 1'b0;
      end
      if (done & unread_reg & ~i_rx_read) begin
        o_rx_overrun <= 1'b1;
      end else if (i_flag_clear) begin
        o_rx_overrun <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq      <= 1'b0;
      o_wake_req <= 1'b0;
    end else begin
      o_irq      <= o_transfer_done_flag & ctrl_reg.transfer_irq_enable;
      o_wake_req <= o_transfer_done_flag & ctrl_reg.transfer_irq_enable
                  & i_idle_sleep;
    end
  end

  // ----------------------------------------
  // Pin drive and direction override
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sck_oe     <= 1'b0;
      o_mosi_oe    <= 1'b0;
      o_miso_oe    <= 1'b0;
      o_data_ready <= 1'b0;
      o_ctrl       <= CTRL_RESET;
    end else begin
      o_sck_oe     <= enabled & ctrl_reg.master_select_bit & i_pin_dir.sck_dir;
      o_mosi_oe    <= enabled & ctrl_reg.master_select_bit & i_pin_dir.mosi_dir;
      o_miso_oe    <= enabled & ~ctrl_reg.master_select_bit & ~ss_n_s
                    & i_pin_dir.miso_dir;
      o_data_ready <= enabled & ~busy & ~start
                    & (fifo_in_ready | ~ctrl_reg.master_select_bit);
      o_ctrl       <= ctrl_reg;
    end
  end

  assign o_sck_o  = sck_level_reg;
  assign o_mosi_o = out_bit_reg;
  assign o_miso_o = out_bit_reg;

  rx_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_in_valid  (done),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (rx_next),
    .o_out_valid (o_stream_valid),
    .i_out_ready (i_stream_ready),
    .o_out_data  (o_stream_data)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Cycles spent in the current master byte
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      byte_cyc_reg <= 11'h000;
    end else if (start) begin
      byte_cyc_reg <= 11'h000;
    end else if (state_reg == ST_MASTER) begin
      byte_cyc_reg <= byte_cyc_reg + 11'h001;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence seq_start;
    start ##1 (state_reg == ST_MASTER);
  endsequence

  sequence seq_byte_run;
    ##15 (state_reg == ST_MASTER);
  endsequence

  a_master_eight_bits: assert property (seq_start |-> seq_byte_run)
    else $error("master byte ended too early");
  a_master_byte_bound: assert property ((state_reg == ST_MASTER)
      |-> byte_cyc_reg <= 11'h406)
    else $error("master byte did not end in time");
  a_done_sets_flag: assert property (done |=> o_transfer_done_flag)
    else $error("done flag missing after byte");
  a_done_stops_clock: assert property (m_edge && done |=> state_reg == ST_IDLE)
    else $error("clock generator kept running");
  a_irq_follows: assert property (o_transfer_done_flag && ctrl_reg.transfer_irq_enable
      && !i_ctrl_wr |=> o_irq)
    else $error("interrupt request missing");
  a_slave_float: assert property (ss_n_s |=> !o_miso_oe)
    else $error("MISO driven while deselected");
  a_master_miso_in: assert property (ctrl_reg.master_select_bit |=> !o_miso_oe)
    else $error("MISO driven in master mode");
  a_collide_flag: assert property (collide |=> o_write_collision_flag && $stable(tx_reg))
    else $error("collision not flagged or data taken");
  a_fault_drop: assert property (fault |=> !ctrl_reg.master_select_bit
      && o_transfer_done_flag)
    else $error("select fault not handled");
  a_power_idle: assert property (!enabled |=> state_reg == ST_IDLE)
    else $error("port active while disabled");
  a_rx_buffer: assert property (done |=> o_rx_data == $past(rx_next))
    else $error("receive buffer not loaded");
  a_flag_set_wins: assert property (done && i_flag_clear |=> o_transfer_done_flag)
    else $error("done flag lost to clear");
  a_edge_period: assert property (m_edge && !done && !fault
      |=> half_cnt_reg == $past(half_sel) - 6'h01)
    else $error("wrong clock divisor");

endmodule

// ==== design/spi_port_pkg.sv ====
// Constants and carrier types for the serial peripheral port
// Notes on behaviour
// - Data goes out on MOSI and in on MISO in one shared clocked exchange.
// - Master never drives slave select; software handles it as a plain pin.
// - Master data write starts the clock generator, which shifts exactly eight bits; the code ignores a master write while the receive FIFO is full.
// - After a byte the master clock stops and the done flag sets.
// - Done flag with interrupt enable raises an interrupt request, master or slave.
// - Master starts the next byte on a new data write after completion; the code does not take the write while the receive FIFO is full.
// - Last received byte is held in a receive buffer for reading.
// - Slave with select high stays inactive, MISO not driven.
// - Slave may load data while deselected; it shifts only once selected.
// - Slave accepts new transmit data before the received byte is read.
// - Transmit is single buffered; writes during a shift are not taken.
// - Receive is double buffered; an unread byte is overwritten by the next.
// - Enabled port forces MISO input in master, MOSI SCK select input in slave.
// - Port stays disabled while its power reduce bit is one.
// - Bit order selects least or most significant bit first.
// - Master offers seven clock rates, including divide by two.
// - Port runs in idle sleep and a done transfer can wake the processor.
// - Rate bits with double bit pick divisor 4,16,64,128 or 2,8,32,64.
// - Idle level bit sets SCK idle; sample edge bit picks sample edge.
// - Data write during a transfer sets the write collision flag.
// - Master with select input driven low drops to slave and sets done flag.
package spi_port_pkg;

  localparam int          BYTE_W        = 8;
  localparam int          EDGES_BYTE    = 16;
  localparam int          RX_FIFO_DEPTH = 32;
  localparam int          CLK_PERIOD_NS = 40;
  localparam logic [5:0]  HALF_DIV4     = 6'h02;
  localparam logic [5:0]  HALF_DIV16    = 6'h08;
  localparam logic [5:0]  HALF_DIV64    = 6'h20;
  localparam logic [5:0]  HALF_DIV128   = 6'h40 - 6'h01;
  localparam logic [5:0]  HALF_DIV2     = 6'h01;
  localparam logic [5:0]  HALF_DIV8     = 6'h04;
  localparam logic [5:0]  HALF_DIV32    = 6'h10;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  localparam logic [3:0]  SYNC_RESET    = 4'h4;

  typedef struct packed {
    logic       transfer_irq_enable;
    logic       bit_order_select;
    logic       master_select_bit;
    logic       idle_level_select;
    logic       sample_edge_select;
    logic       rate_select_high;
    logic       rate_select_low;
    logic       double_rate_bit;
  } port_control_type;

  localparam port_control_type CTRL_RESET = '{default: 1'b0};

  typedef struct packed {
    logic       mosi_dir;
    logic       miso_dir;
    logic       sck_dir;
    logic       ss_is_input;
  } pin_dir_type;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h1,
    ST_MASTER = 3'h2,
    ST_SLAVE  = 3'h4
  } port_state_type;

endpackage

// ==== design/rx_fifo.sv ====
// Receive byte FIFO with valid and ready on both sides
`timescale 1ns/10ps
module rx_fifo
  import spi_port_pkg::*;
#(
  parameter int WIDTH = BYTE_W,
  parameter int DEPTH = RX_FIFO_DEPTH
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("rx_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  assign o_in_ready  = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
  assign o_out_valid = wr_ptr_reg != rd_ptr_reg;
  assign o_out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

endmodule

// ==== tb/spi_far_end.sv ====
// Far-end serial slave model, clock idles low, samples on the rising edge
`timescale 1ns/10ps
module spi_far_end (
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_ss_n,
  input  wire logic [7:0] i_tx,
  output logic            o_miso,
  output logic [7:0]      o_rx
);
  logic [7:0] tx_reg = 8'h00;
  initial o_rx = 8'h00;
  // ----------------------------------------
  // Shift logic
  // ----------------------------------------
  always @(negedge i_ss_n) tx_reg = i_tx;
  always @(negedge i_sck) begin
    if (!i_ss_n) tx_reg = {tx_reg[6:0], 1'b0};
  end
  always @(posedge i_sck) begin
    if (!i_ss_n) o_rx = {o_rx[6:0], i_mosi};
  end
  // Released line shows the inverse of the top bit of tx_reg
  assign o_miso = i_ss_n ? ~tx_reg[7] : tx_reg[7];
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the serial peripheral port
`timescale 1ns/10ps
module tb;
  import spi_port_pkg::*;
  logic             clk = 1'b0, rst = 1'b1, pwr = 1'b0, sleep = 1'b0, ctl_wr = 1'b0;
  logic             dwr = 1'b0, rd = 1'b0, fclr = 1'b0, srdy = 1'b1, slave = 1'b0;
  logic             tsck = 1'b0, tmosi = 1'b0, ss_n = 1'b1, irq_exp = 1'b0;
  logic [7:0]       wdata = 8'h00, ptx = 8'h00;
  port_control_type ctl = CTRL_RESET;
  pin_dir_type      dir = 4'hE;
  wire logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, miso_f;
  wire logic        done, write_collision_flag, ovr, drdy, irq, wake, svld;
  wire logic [7:0]  rx, sdata, frx;
  port_control_type ctl_o;
  int               mismatches = 0, compares = 0, gap = 0, edges = 0;
  time              lastt = 0;
  int               halfs [8] = '{2, 8, 32, 64, 1, 4, 16, 32};

  always #20 clk = ~clk;
  always @(sck_o) begin
    gap = int'(($time - lastt) / 40);
    lastt = $time;
    edges++;
  end

  serial_peripheral_port uut (
    .i_ref_clk(clk), .i_rst(rst), .i_enable(1'b1), .i_power_reduce(pwr),
    .i_idle_sleep(sleep), .i_ctrl_wr(ctl_wr), .i_ctrl(ctl), .i_pin_dir(dir),
    .i_data_wr(dwr), .i_data_wdata(wdata), .i_rx_read(rd), .i_flag_clear(fclr),
    .i_stream_ready(srdy), .i_sck_i(slave ? tsck : sck_o),
    .i_mosi_i(slave ? tmosi : mosi_o), .i_miso_i(miso_f), .i_ss_n_i(ss_n),
    .o_sck_o(sck_o), .o_sck_oe(sck_oe), .o_mosi_o(mosi_o), .o_mosi_oe(mosi_oe),
    .o_miso_o(miso_o), .o_miso_oe(miso_oe), .o_ctrl(ctl_o), .o_rx_data(rx),
    .o_transfer_done_flag(done), .o_write_collision_flag(write_collision_flag), .o_rx_overrun(ovr),
    .o_data_ready(drdy), .o_irq(irq), .o_wake_req(wake), .o_stream_valid(svld),
    .o_stream_data(sdata)
  );
  spi_far_end far (
    .i_sck(sck_o), .i_mosi(mosi_o), .i_ss_n(ss_n), .i_tx(ptx), .o_miso(miso_f),
    .o_rx(frx)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic setctl(input logic [7:0] v, input logic s);
    @(posedge clk);
    ctl <= v;
    ctl_wr <= 1'b1;
    sleep <= s;
    irq_exp = v[7];
    @(posedge clk);
    ctl_wr <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    wdata <= d;
    dwr <= 1'b1;
    @(posedge clk);
    dwr <= 1'b0;
  endtask
  task automatic clr(input logic r);
    @(posedge clk);
    fclr <= 1'b1;
    rd <= r;
    @(posedge clk);
    fclr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic pins(input logic s, input logic m, input logic n);
    @(posedge clk);
    tsck <= s;
    tmosi <= m;
    ss_n <= n;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    if (n == 3000) begin
      mismatches++;
      finish_test();
    end
  endtask
  task automatic mxfer(input logic [7:0] d, p, ef, er);
    ptx = p;
    pins(1'b0, 1'b0, 1'b0);
    edges = 0;
    wr(d);
    wait_done();
    chk(frx, ef);
    chk(rx, er);
    chk(edges[7:0], 8'h10);
    tick(1);
    chk(irq, irq_exp);
    chk(wake, irq_exp & sleep);
    chk(miso_oe, 1'b0);
    pins(1'b0, 1'b0, 1'b1);
    clr(1'b1);
  endtask
  task automatic sl_byte(input logic [7:0] m, input logic [7:0] e);
    logic [7:0] g;
    for (int i = 7; i >= 0; i--) begin
      pins(1'b0, m[i], 1'b0);
      tick(8);
      g[i] = miso_o;
      pins(1'b1, m[i], 1'b0);
      tick(8);
    end
    pins(1'b0, m[0], 1'b0);
    tick(8);
    chk(g, e);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_back();
    ptx = 8'h81;
    pins(1'b0, 1'b0, 1'b0);
    wr(8'h5A);
    wait_done();
    chk(rx, 8'h81);
    clr(1'b1);
    wr(8'h69);
    tick(20);
    wr(8'h11);
    tick(2);
    chk(write_collision_flag, 1'b1);
    wait_done();
    chk(frx, 8'h69);
    chk(rx, 8'h00);
    pins(1'b0, 1'b0, 1'b1);
    clr(1'b1);
  endtask
  task automatic s_rates();
    logic [2:0] r;
    for (int k = 0; k < 8; k++) begin
      r = k[2:0];
      setctl(8'h20 | {5'h00, r[1:0], r[2]}, 1'b0);
      mxfer(8'hC5 ^ r, 8'h00, 8'hC5 ^ r, 8'h00);
      chk(gap[7:0], halfs[k][7:0]);
    end
  endtask
  task automatic s_power();
    @(posedge clk);
    pwr <= 1'b1;
    edges = 0;
    wr(8'h77);
    tick(80);
    chk(done, 1'b0);
    chk(edges[7:0], 8'h00);
    chk(sck_oe, 1'b0);
    @(posedge clk);
    pwr <= 1'b0;
  endtask
  task automatic s_fault();
    setctl(8'hA2, 1'b0);
    @(posedge clk);
    dir <= 4'hF;
    pins(1'b0, 1'b0, 1'b0);
    wait_done();
    tick(1);
    chk(ctl_o.master_select_bit, 1'b0);
    chk(irq, 1'b1);
    pins(1'b0, 1'b0, 1'b1);
    clr(1'b1);
  endtask
  task automatic s_slave();
    setctl(8'h80, 1'b0);
    @(posedge clk);
    slave <= 1'b1;
    tick(4);
    chk(miso_oe, 1'b0);
    wr(8'h5A);
    for (int i = 0; i < 8; i++) begin
      pins(1'b1, 1'b1, 1'b1);
      tick(8);
      pins(1'b0, 1'b0, 1'b1);
      tick(8);
    end
    chk(done, 1'b0);
    pins(1'b0, 1'b0, 1'b0);
    tick(8);
    sl_byte(8'hC3, 8'h5A);
    chk(done, 1'b1);
    chk(rx, 8'hC3);
    chk({mosi_oe, sck_oe}, 8'h00);
    clr(1'b0);
    wr(8'h96);
    sl_byte(8'h3C, 8'h96);
    chk(rx, 8'h3C);
    chk(ovr, 1'b1);
    pins(1'b0, 1'b0, 1'b1);
    tick(4);
    chk(miso_oe, 1'b0);
    @(posedge clk);
    slave <= 1'b0;
    dir <= 4'hE;
    clr(1'b1);
  endtask
  task automatic s_fifo();
    setctl(8'hA3, 1'b0);
    @(posedge clk);
    srdy <= 1'b0;
    for (int k = 0; k < 32; k++) mxfer(k[7:0], k[7:0] ^ 8'h5A, k[7:0], k[7:0] ^ 8'h5A);
    chk(drdy, 1'b0);
    edges = 0;
    wr(8'hEE);
    tick(40);
    chk({done, edges[6:0]}, 8'h00);
    @(posedge clk);
    srdy <= 1'b1;
    #1;
    for (int k = 0; k < 32; k++) begin
      chk({7'h00, svld}, 8'h01);
      chk(sdata, k[7:0] ^ 8'h5A);
      tick(1);
    end
    chk(svld, 1'b0);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    tick(3);
    setctl(8'hA2, 1'b1);
    mxfer(8'hA5, 8'h3C, 8'hA5, 8'h3C);
    s_back();
    setctl(8'h62, 1'b1);
    mxfer(8'h01, 8'hC8, 8'h80, 8'h13);
    s_rates();
    s_power();
    s_fault();
    s_slave();
    s_fifo();
    finish_test();
  end
endmodule
